/* File: design/bflg_pkg.sv */
// boot flash lock guard: shared constants and carrier types
// assumes a core that presents store/read requests with a 16-bit pointer
`default_nettype none
package bflg_pkg;
    // lock field encodings, 1 = unprogrammed, 0 = programmed
    localparam logic [1:0] LOCK_MODE1 = 2'h3; // no restriction
    localparam logic [1:0] LOCK_MODE2 = 2'h2; // store blocked
    localparam logic [1:0] LOCK_MODE3 = 2'h0; // store and cross read blocked
    localparam logic [1:0] LOCK_MODE4 = 2'h1; // cross read blocked
    localparam logic [1:0] LOCK_ERASED = 2'h3;
    localparam logic [15:0] APP_RESET_ADDR = 16'h0000;
    localparam int PTR_W = 16;
    localparam int WORD_BITS_DEF = 6;   // word-in-page bits (words/page 64)
    localparam int BOOT_START_DEF = 16'h3800; // boot start word address
    // store command kinds
    typedef enum logic [1:0] {
        BFLG_CMD_FILL  = 2'h0,
        BFLG_CMD_ERASE = 2'h1,
        BFLG_CMD_WRITE = 2'h3,
        BFLG_CMD_LOCK  = 2'h2
    } bflg_cmd_type;
    // store request from the core
    typedef struct packed {
        logic         valid;
        bflg_cmd_type cmd;
        logic [7:0]   lockData;  // lock value for lock command, bits 5..2
    } bflg_store_type;
    // pointer pair from the register file
    typedef struct packed {
        logic [7:0] pointerHighByte;
        logic [7:0] pointerLowByte;
    } bflg_ptr_type;
    // guard states
    typedef enum logic [1:0] {
        BFLG_IDLE = 2'h0,
        BFLG_BUSY = 2'h1
    } bflg_state_type;
endpackage
`default_nettype wire

/* File: design/boot_flash_lock_guard.sv */
// boot flash lock guard: checks store and program-read requests against
// the boot lock fields, latches page/word address, gives reset vector
// assumes core requests are synchronous single-cycle pulses on sys_clk
`default_nettype none
module boot_flash_lock_guard #(
    parameter int WORD_BITS  = bflg_pkg::WORD_BITS_DEF,
    parameter int BOOT_START = bflg_pkg::BOOT_START_DEF,
    parameter int OP_CYCLES  = 4
) (
    input  wire logic                     sys_clk,
    input  wire logic                     reset,
    input  wire bflg_pkg::bflg_store_type storeReq,
    input  wire logic                     readReq,
    input  wire bflg_pkg::bflg_ptr_type   pointer,
    input  wire logic [15:0]              execAddr,
    input  wire logic                     vectorsInBoot,
    input  wire logic                     chipErase,
    input  wire logic                     extLockWrite,
    input  wire logic [3:0]               extLockData,
    input  wire logic                     boot_reset_select_fuse,
    output var  logic                     storeGrant,
    output var  logic                     storeDenied,
    output var  logic [15:0]              pageAddr,
    output var  logic [15:0]              wordAddr,
    output var  logic                     busy,
    output var  logic                     readGrant,
    output var  logic                     readDenied,
    output var  logic [15:0]              readByteAddr,
    output var  logic                     irqBlock,
    output var  logic [15:0]              resetVector,
    output var  logic [1:0]               app_section_lock_mode,
    output var  logic [1:0]               boot_section_lock_mode
);
    // ************************************************************
    // section decode
    // ************************************************************
    localparam logic [15:0] BOOT_BASE = 16'(BOOT_START);
    localparam logic [15:0] WORD_MASK = 16'((1 << WORD_BITS) - 1);
    localparam logic [7:0]  CNT_INIT  = 8'(OP_CYCLES);

    logic [15:0] ptrWord;    // raw pointer as word address
    logic [15:0] ptrByte;    // raw pointer as byte address
    logic        execInBoot; // core currently runs boot code
    logic        tgtBoot;    // store target lies in boot section
    logic        rdTgtBoot;  // read target lies in boot section

    // pointer pair, high byte first
    assign ptrByte = {pointer.pointerHighByte, pointer.pointerLowByte};
    assign ptrWord = ptrByte;
    // stores treat the pointer as a word address; only reads drop bit 0
    assign execInBoot = execAddr >= BOOT_BASE;
    assign tgtBoot    = ptrWord >= BOOT_BASE;
    // reads are byte addressed, so the word is pointer without bit 0
    assign rdTgtBoot  = {1'b0, ptrByte[15:1]} >= BOOT_BASE;

    // ************************************************************
    // lock fields
    // ************************************************************
    logic [1:0] appLock_r, appLock_nxt;   // application lock field
    logic [1:0] bootLock_r, bootLock_nxt; // boot loader lock field

    // next lock values: outside chip erase, bits may only be programmed (1 -> 0)
    always_comb begin
        appLock_nxt  = appLock_r;
        bootLock_nxt = bootLock_r;
        if (chipErase) begin
            // the only way back to unprogrammed apart from reset
            appLock_nxt  = bflg_pkg::LOCK_ERASED;
            bootLock_nxt = bflg_pkg::LOCK_ERASED;
        end else begin
            if (extLockWrite) begin
                // external programming can only program bits
                appLock_nxt  = appLock_nxt & extLockData[1:0];
                bootLock_nxt = bootLock_nxt & extLockData[3:2];
            end
            // lock store: pointer is never looked at
            if (storeReq.valid && execInBoot && !busy &&
                storeReq.cmd == bflg_pkg::BFLG_CMD_LOCK) begin
                appLock_nxt  = appLock_nxt & storeReq.lockData[3:2];
                bootLock_nxt = bootLock_nxt & storeReq.lockData[5:4];
            end
        end
    end

    // lock registers come up unprogrammed
    // no nonvolatile copy here: a reset forgets programmed lock bits
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            appLock_r  <= bflg_pkg::LOCK_ERASED;
            bootLock_r <= bflg_pkg::LOCK_ERASED;
        end else begin
            appLock_r  <= appLock_nxt;
            bootLock_r <= bootLock_nxt;
        end
    end

    // ************************************************************
    // permission decode
    // ************************************************************
    logic appStoreOk;  // stores into application allowed
    logic bootStoreOk; // stores into boot allowed
    logic appReadOk;   // boot code may read application
    logic bootReadOk;  // application code may read boot
    logic storeOk;     // this store may proceed
    logic readOk;      // this read may proceed

    // general lock modes never enter these terms
    always_comb begin
        // mode 1 passes everything
        appStoreOk  = appLock_r[0];  // modes 2,3 clear low bit
        appReadOk   = appLock_r[1];  // modes 3,4 clear high bit
        bootStoreOk = bootLock_r[0];
        bootReadOk  = bootLock_r[1];
        // store: only from boot code, target checked except for lock stores
        storeOk = execInBoot &&
                  (storeReq.cmd == bflg_pkg::BFLG_CMD_LOCK ||
                   (tgtBoot ? bootStoreOk : appStoreOk));
        // reads only cross-checked when leaving own section
        if (execInBoot && !rdTgtBoot)
            readOk = appReadOk;
        else if (!execInBoot && rdTgtBoot)
            readOk = bootReadOk;
        else
            readOk = 1'b1;
    end

    // ************************************************************
    // store operation latch
    // ************************************************************
    bflg_pkg::bflg_state_type state_r, state_nxt; // operation state
    logic [15:0] page_r, page_nxt;   // latched page address
    logic [15:0] word_r, word_nxt;   // latched word in page
    logic [7:0]  cnt_r, cnt_nxt;     // operation length counter
    logic        grant_nxt, deny_nxt;
    logic        busy_nxt;           // next busy level

    // a refused store never reaches the flash port
    always_comb begin
        state_nxt = state_r;
        page_nxt  = page_r;
        word_nxt  = word_r;
        cnt_nxt   = cnt_r;
        grant_nxt = 1'b0;
        deny_nxt  = 1'b0;
        unique case (state_r)
            bflg_pkg::BFLG_IDLE: begin
                if (storeReq.valid) begin
                    if (storeOk) begin
                        grant_nxt = 1'b1;
                        if (storeReq.cmd != bflg_pkg::BFLG_CMD_LOCK) begin
                            // split and hold address
                            page_nxt = ptrWord & ~WORD_MASK;
                            word_nxt = ptrWord & WORD_MASK;
                        end
                        state_nxt = bflg_pkg::BFLG_BUSY;
                        cnt_nxt   = CNT_INIT;
                    end else begin
                        deny_nxt = 1'b1;
                    end
                end
            end
            bflg_pkg::BFLG_BUSY: begin
                // pointer changes now have no effect
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r == 8'h01)
                    state_nxt = bflg_pkg::BFLG_IDLE;
            end
            // two of the four codes are unused; fall back to idle
            default: begin
                state_nxt = bflg_pkg::BFLG_IDLE;
            end
        endcase
        // busy is registered so the port comes straight from a flop
        busy_nxt = state_nxt == bflg_pkg::BFLG_BUSY;
    end

    // operation registers
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_r     <= bflg_pkg::BFLG_IDLE;
            page_r      <= 16'h0000;
            word_r      <= 16'h0000;
            cnt_r       <= 8'h00;
            storeGrant  <= 1'b0;
            storeDenied <= 1'b0;
            busy        <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            page_r      <= page_nxt;
            word_r      <= word_nxt;
            cnt_r       <= cnt_nxt;
            storeGrant  <= grant_nxt;
            storeDenied <= deny_nxt;
            busy        <= busy_nxt;
        end
    end
    assign pageAddr = page_r;
    assign wordAddr = word_r;

    // ************************************************************
    // program read, interrupts, reset vector
    // ************************************************************
    logic        rdGrant_nxt, rdDeny_nxt, irq_nxt;
    logic [15:0] rdAddr_nxt, vec_nxt;

    // read gating, interrupt masking and vector choice
    always_comb begin
        rdGrant_nxt = readReq && readOk;
        rdDeny_nxt  = readReq && !readOk; // locked data stays hidden
        rdAddr_nxt  = readReq && readOk ? ptrByte : readByteAddr;
        // vectors in the other section and cross reads locked
        irq_nxt = (!execInBoot && vectorsInBoot && !appLock_r[1]) ||
                  (execInBoot && !vectorsInBoot && !bootLock_r[1]);
        // fuse is an input only; no core path can change it
        vec_nxt = boot_reset_select_fuse ? bflg_pkg::APP_RESET_ADDR
                                         : BOOT_BASE;
    end

    // output registers
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            readGrant    <= 1'b0;
            readDenied   <= 1'b0;
            readByteAddr <= 16'h0000;
            irqBlock     <= 1'b0;
            resetVector  <= bflg_pkg::APP_RESET_ADDR;
        end else begin
            readGrant    <= rdGrant_nxt;
            readDenied   <= rdDeny_nxt;
            readByteAddr <= rdAddr_nxt;
            irqBlock     <= irq_nxt;
            resetVector  <= vec_nxt;
        end
    end
    assign app_section_lock_mode  = appLock_r;
    assign boot_section_lock_mode = bootLock_r;

    // ************************************************************
    // checks
    // ************************************************************
    a_app_store_lock: assert property (
        @(posedge sys_clk) disable iff (reset)
        storeReq.valid && !busy && !tgtBoot && !appLock_r[0] &&
        storeReq.cmd != bflg_pkg::BFLG_CMD_LOCK |=> !storeGrant)
        else $error("application store passed a store lock");
    a_boot_store_lock: assert property (
        @(posedge sys_clk) disable iff (reset)
        storeReq.valid && !busy && tgtBoot && !bootLock_r[0] &&
        storeReq.cmd != bflg_pkg::BFLG_CMD_LOCK |=> !storeGrant)
        else $error("boot store passed a store lock");
    a_app_exec_store: assert property (
        @(posedge sys_clk) disable iff (reset)
        storeReq.valid && !busy && !execInBoot |=> storeDenied)
        else $error("store from application not denied");
    a_cross_read_app: assert property (
        @(posedge sys_clk) disable iff (reset)
        readReq && execInBoot && !rdTgtBoot && !appLock_r[1]
        |=> readDenied && !readGrant)
        else $error("boot code read locked application");
    a_cross_read_boot: assert property (
        @(posedge sys_clk) disable iff (reset)
        readReq && !execInBoot && rdTgtBoot && !bootLock_r[1]
        |=> readDenied)
        else $error("application code read locked boot");
    a_free_mode_read: assert property (
        @(posedge sys_clk) disable iff (reset)
        readReq && appLock_r == bflg_pkg::LOCK_MODE1 &&
        bootLock_r == bflg_pkg::LOCK_MODE1 |=> readGrant)
        else $error("unlocked read refused");
    a_lock_sticky: assert property (
        @(posedge sys_clk) disable iff (reset)
        !chipErase |=> (appLock_r & ~$past(appLock_r)) == 2'h0)
        else $error("lock bit cleared without chip erase");
    a_addr_held: assert property (
        @(posedge sys_clk) disable iff (reset)
        busy && $past(busy) |-> $stable(pageAddr))
        else $error("latched page moved during operation");
    a_reset_vec: assert property (
        @(posedge sys_clk) disable iff (reset)
        !boot_reset_select_fuse |=> resetVector == BOOT_BASE)
        else $error("reset vector ignores fuse");
    a_irq_mask: assert property (
        @(posedge sys_clk) disable iff (reset)
        !execInBoot && vectorsInBoot && !appLock_r[1] |=> irqBlock)
        else $error("interrupts not masked in application");

    // store permissions, address latch and refusals
    a_store_free_app: assert property (
        @(posedge sys_clk) disable iff (reset)
        storeReq.valid && !busy && execInBoot && !tgtBoot &&
        appLock_r == bflg_pkg::LOCK_MODE1 |=> storeGrant)
        else $error("unlocked application store refused");
    a_store_free_boot: assert property (
        @(posedge sys_clk) disable iff (reset)
        storeReq.valid && !busy && execInBoot && tgtBoot &&
        bootLock_r == bflg_pkg::LOCK_MODE1 |=> storeGrant)
        else $error("unlocked boot store refused");
    a_page_split: assert property (
        @(posedge sys_clk) disable iff (reset)
        storeReq.valid && !busy && storeOk &&
        storeReq.cmd != bflg_pkg::BFLG_CMD_LOCK |=>
        pageAddr == ($past(ptrWord) & ~WORD_MASK) &&
        wordAddr == ($past(ptrWord) & WORD_MASK))
        else $error("page or word address not split from pointer");
    a_lock_ptr_free: assert property (
        @(posedge sys_clk) disable iff (reset)
        storeReq.valid && !busy && execInBoot &&
        storeReq.cmd == bflg_pkg::BFLG_CMD_LOCK
        |=> storeGrant && $stable(pageAddr) && $stable(wordAddr))
        else $error("lock store depended on the pointer");
    a_refused_quiet: assert property (
        @(posedge sys_clk) disable iff (reset)
        storeReq.valid && !busy && !storeOk
        |=> !busy && $stable(pageAddr) && $stable(wordAddr))
        else $error("refused store started an operation");

    // interrupt masking in boot code and erase of the lock fields
    a_irq_mask_boot: assert property (
        @(posedge sys_clk) disable iff (reset)
        execInBoot && !vectorsInBoot && !bootLock_r[1] |=> irqBlock)
        else $error("interrupts not masked in boot code");
    a_lock_erase: assert property (
        @(posedge sys_clk) disable iff (reset)
        chipErase |=> appLock_r == bflg_pkg::LOCK_ERASED &&
        bootLock_r == bflg_pkg::LOCK_ERASED)
        else $error("chip erase left a lock bit programmed");
endmodule
`default_nettype wire

/* File: tb/bflg_core_model.sv */
// core model: issues store and program-read requests as the cpu would
// assumes the guard answers exactly one cycle after each request
`default_nettype none
module bflg_core_model (
    input  wire logic                     sys_clk,
    output var  bflg_pkg::bflg_store_type storeReq,
    output var  logic                     readReq,
    output var  bflg_pkg::bflg_ptr_type   pointer,
    output var  logic [15:0]              execAddr,
    input  wire logic                     storeGrant,
    input  wire logic                     storeDenied,
    input  wire logic                     readGrant,
    input  wire logic                     readDenied
);
    timeunit 1ns;
    timeprecision 1ps;
    // ***************************************************
    // request tasks
    // ***************************************************
    // idle values at time zero
    initial begin
        storeReq = '0;
        readReq  = 1'b0;
        pointer  = '0;
        execAddr = 16'h0000;
    end
    // one store pulse; address comes from the high/low pointer pair
    task automatic store(input bflg_pkg::bflg_cmd_type c,
                         input logic [15:0] ptr, ex,
                         input logic [7:0] dat, output logic [1:0] ans);
        @(posedge sys_clk) #1;
        storeReq = {1'b1, c, dat};
        pointer  = ptr;
        execAddr = ex;
        @(posedge sys_clk) #1;
        // lock data flips when idle so a stale copy is never trusted
        storeReq = {1'b0, c, ~dat};
        ans      = {storeGrant, storeDenied};
    endtask
    // one program-read pulse, byte addressed
    task automatic read(input logic [15:0] ptr, ex, output logic [1:0] ans);
        @(posedge sys_clk) #1;
        readReq  = 1'b1;
        pointer  = ptr;
        execAddr = ex;
        @(posedge sys_clk) #1;
        readReq = 1'b0;
        ans     = {readGrant, readDenied};
    endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// testbench: drives the guard through the core model and checks answers
// assumes default parameters of the guard (64-word pages, 4-cycle ops)
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] AP = 16'h0100; // app target / app exec
    localparam logic [15:0] BP = 16'hF000; // boot target
    localparam logic [15:0] BX = 16'h3900; // exec inside boot section
    localparam logic [15:0] MSK = (16'h1 << bflg_pkg::WORD_BITS_DEF) - 1;
    logic                     sys_clk, reset, vectorsInBoot, chipErase;
    logic                     extLockWrite, fuse, storeGrant, storeDenied;
    logic                     busy, readGrant, readDenied, irqBlock;
    logic [3:0]               extLockData;
    logic [15:0]              execAddr, pageAddr, wordAddr;
    logic [15:0]              readByteAddr, resetVector;
    logic [1:0]               appMode, bootMode, a, m;
    logic                     readReq;
    bflg_pkg::bflg_store_type storeReq;
    bflg_pkg::bflg_ptr_type   pointer;
    logic [1:0]               modes [4];
    int                       errors, checks;

    boot_flash_lock_guard i_boot_flash_lock_guard (
        .sys_clk(sys_clk), .reset(reset), .storeReq(storeReq),
        .readReq(readReq), .pointer(pointer), .execAddr(execAddr),
        .vectorsInBoot(vectorsInBoot), .chipErase(chipErase),
        .extLockWrite(extLockWrite), .extLockData(extLockData),
        .boot_reset_select_fuse(fuse), .storeGrant(storeGrant),
        .storeDenied(storeDenied), .pageAddr(pageAddr),
        .wordAddr(wordAddr), .busy(busy), .readGrant(readGrant),
        .readDenied(readDenied), .readByteAddr(readByteAddr),
        .irqBlock(irqBlock), .resetVector(resetVector),
        .app_section_lock_mode(appMode), .boot_section_lock_mode(bootMode));
    bflg_core_model i_bflg_core_model (
        .sys_clk(sys_clk), .storeReq(storeReq), .readReq(readReq),
        .pointer(pointer), .execAddr(execAddr), .storeGrant(storeGrant),
        .storeDenied(storeDenied), .readGrant(readGrant),
        .readDenied(readDenied));
    // ***************************************************
    // helpers
    // ***************************************************
    // 50 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // the only place the run ends
    task automatic print_verdict();
        if (errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // expected {grant, denied} pair
    function automatic logic [1:0] ok(input logic b);
        return b ? 2'b10 : 2'b01;
    endfunction
    // store after busy drops, so requests keep their spacing
    task automatic st(input bflg_pkg::bflg_cmd_type c, input logic [15:0] p,
                      e, input logic [7:0] d, output logic [1:0] r);
        int n = 0;
        while (busy !== 1'b0) begin
            @(posedge sys_clk) #1;
            n++;
            if (n > 20) begin
                errors++;
                print_verdict();
            end
        end
        i_bflg_core_model.store(c, p, e, d, r);
    endtask
    // chip erase, then program both fields from outside
    task automatic setlk(input logic [1:0] v);
        @(posedge sys_clk) #1;
        chipErase = 1'b1;
        @(posedge sys_clk) #1;
        chipErase    = 1'b0;
        extLockWrite = 1'b1;
        extLockData  = {v, v};
        @(posedge sys_clk) #1;
        extLockWrite = 1'b0;
        @(posedge sys_clk) #1;
    endtask
    // ***************************************************
    // main sequence
    // ***************************************************
    initial begin
        modes = '{bflg_pkg::LOCK_MODE1, bflg_pkg::LOCK_MODE2,
                  bflg_pkg::LOCK_MODE3, bflg_pkg::LOCK_MODE4};
        {reset, vectorsInBoot, chipErase, extLockWrite} = 4'hF & 4'h8;
        extLockData = 4'hF;
        // fuse is only ever moved by the bench, as an outside programmer
        fuse = 1'b0;
        repeat (8) @(posedge sys_clk);
        #1 reset = 1'b0;
        `CHK({appMode, bootMode}, 4'hF)
        repeat (2) @(posedge sys_clk);
        #1 `CHK(resetVector, 16'(bflg_pkg::BOOT_START_DEF))
        // every lock mode on both fields
        foreach (modes[i]) begin
            m = modes[i];
            setlk(m);
            `CHK({appMode, bootMode}, {m, m})
            st(bflg_pkg::BFLG_CMD_ERASE, AP, BX, 8'hFF, a);
            `CHK(a, ok(m[0]))
            `CHK(busy, m[0])
            st(bflg_pkg::BFLG_CMD_ERASE, BP, BX, 8'hFF, a);
            `CHK(a, ok(m[0]))
            i_bflg_core_model.read(AP, BX, a);
            `CHK(a, ok(m[1]))
            i_bflg_core_model.read(BP, AP, a);
            `CHK(a, ok(m[1]))
            vectorsInBoot = 1'b1;
            repeat (2) @(posedge sys_clk);
            #1 `CHK(irqBlock, ~m[1])
            i_bflg_core_model.read(BP, BX, a);
            `CHK(a, 2'b10)
            vectorsInBoot = 1'b0;
            repeat (2) @(posedge sys_clk);
            #1 `CHK(irqBlock, ~m[1])
        end
        setlk(bflg_pkg::LOCK_ERASED);
        st(bflg_pkg::BFLG_CMD_ERASE, AP, AP, 8'hFF, a);
        `CHK(a, 2'b01)
        st(bflg_pkg::BFLG_CMD_FILL, 16'h0102, BX, 8'hFF, a);
        `CHK(a, 2'b10)
        // address held while the pointer moves on
        st(bflg_pkg::BFLG_CMD_WRITE, 16'hF0A5, BX, 8'hFF, a);
        i_bflg_core_model.read(16'h0101, BX, a);
        `CHK(readByteAddr, 16'h0101)
        `CHK({pageAddr, wordAddr}, {16'hF0A5 & ~MSK, 16'hF0A5 & MSK})
        // lock store ignores the pointer; only the application field is programmed
        st(bflg_pkg::BFLG_CMD_LOCK, 16'h0001, BX, 8'hF0, a);
        `CHK({appMode, bootMode, pageAddr}, {4'h3, 16'hF0A5 & ~MSK})
        st(bflg_pkg::BFLG_CMD_ERASE, BP, BX, 8'hFF, a);
        `CHK(a, 2'b10)
        st(bflg_pkg::BFLG_CMD_LOCK, AP, BX, 8'hCF, a);
        `CHK({appMode, bootMode}, 4'h0)
        st(bflg_pkg::BFLG_CMD_LOCK, BP, AP, 8'h00, a);
        `CHK(a, 2'b01)
        `CHK(resetVector, 16'(bflg_pkg::BOOT_START_DEF))
        setlk(bflg_pkg::LOCK_ERASED);
        `CHK({appMode, bootMode}, 4'hF)
        fuse = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 `CHK(resetVector, bflg_pkg::APP_RESET_ADDR)
        print_verdict();
    end
endmodule
`default_nettype wire
